//--- design/pif_consts.svh
// constants for the peripheral interrupt flag block
// assumes inclusion by the flag module, the property checker and the bench; the package does not include it
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH
`define PIF_OFS_FLAGS_ONE 12'h000
`define PIF_OFS_FLAGS_TWO 12'h004
`define PIF_OFS_ENABLE_ONE 12'h008
`define PIF_OFS_ENABLE_TWO 12'h00c
`define PIF_OFS_CONTROL 12'h010
`define PIF_OFS_IRQ_STATUS 12'h014
`define PIF_OFS_IRQ_MASK 12'h018
`define PIF_FLAGS_RESET 8'h00
`define PIF_TWO_IMPL_MASK 8'hf5
`define PIF_TWO_IMPL_MASK_SMALL 8'hf4
`define PIF_BIT_EEPROM 7
`define PIF_BIT_CONV 6
`define PIF_BIT_RX 5
`define PIF_BIT_TX 4
`define PIF_BIT_SYNC 3
`define PIF_BIT_CC1 2
`define PIF_BIT_T2 1
`define PIF_BIT_T1 0
`define PIF_BIT_OSC 7
`define PIF_BIT_CMP2 6
`define PIF_BIT_CMP1 5
`define PIF_BIT_LCD 4
`define PIF_BIT_LVD 2
`define PIF_BIT_CC2 0
`define PIF_CTL_GIE 0
`define PIF_CTL_PERIPHERAL_IRQ_MASTER_ENABLE 1
`define PIF_RESP_OKAY 2'b00
`define PIF_RESP_SLVERR 2'b10
`endif

//--- design/pif_pkg.sv
// types for the peripheral interrupt flag block
// assumes nothing beyond the constants header
package pif_pkg;
    typedef enum logic [1:0]
    {
        PIF_CC_CAPTURE = 2'b00,
        PIF_CC_COMPARE = 2'b01,
        PIF_CC_PWM = 2'b10
    } pif_ccmode_e;
    typedef enum logic [2:0]
    {
        PIF_RD_IDLE = 3'b001,
        PIF_RD_RESP = 3'b010,
        PIF_RD_HOLD = 3'b100
    } pif_rd_e;
    typedef logic [7:0] pif_byte_t;
endpackage : pif_pkg

//--- design/pif_flags.sv
// peripheral interrupt request flags with axi4-lite register access
// assumes event inputs are one-cycle pulses synchronous to ref_clk, except the comparator outputs, which are levels whose changes count
`timescale 1ns/1ps
`include "pif_consts.svh"
module pif_flags #(
    parameter bit HAS_CC2 = 1'b1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic eeprom_write_done,
    input wire logic conversion_done,
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic sync_serial_done,
    input wire logic capcomp_one_capture,
    input wire logic capcomp_one_match,
    input wire pif_pkg::pif_ccmode_e capcomp_one_mode,
    input wire logic timer_two_match,
    input wire logic timer_one_overflow,
    input wire logic oscillator_fail,
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic display_driver_event,
    input wire logic low_voltage_event,
    input wire logic capcomp_two_capture,
    input wire logic capcomp_two_match,
    input wire pif_pkg::pif_ccmode_e capcomp_two_mode,
    output logic peripheral_irq_request,
    output logic core_irq_request,
    output logic irq
);
    import pif_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state
    pif_byte_t flags_one;
    pif_byte_t flags_two;
    pif_byte_t enable_one;
    pif_byte_t enable_two;
    logic global_irq_enable;
    logic peripheral_irq_master_enable;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic cmp1_q;
    logic cmp2_q;
    pif_byte_t ev_one;
    pif_byte_t ev_two;
    pif_byte_t two_mask;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    pif_rd_e rd_state;

    assign two_mask = HAS_CC2 ? `PIF_TWO_IMPL_MASK : `PIF_TWO_IMPL_MASK_SMALL;

    function automatic logic cc_event(input pif_ccmode_e mode,
                                      input logic cap,
                                      input logic cmp);
        begin
            case (mode)
                PIF_CC_CAPTURE: cc_event = cap;
                PIF_CC_COMPARE: cc_event = cmp;
                default: cc_event = 1'b0;
            endcase
        end
    endfunction : cc_event

    ////////////////////////////////////////////////////////////////////////
    // event vectors, independent of any enable
    always_comb
    begin
        ev_one = 8'h00;
        ev_one[`PIF_BIT_EEPROM] = eeprom_write_done;
        ev_one[`PIF_BIT_CONV] = conversion_done;
        ev_one[`PIF_BIT_SYNC] = sync_serial_done;
        ev_one[`PIF_BIT_CC1] = cc_event(capcomp_one_mode,
            capcomp_one_capture, capcomp_one_match);
        ev_one[`PIF_BIT_T2] = timer_two_match;
        ev_one[`PIF_BIT_T1] = timer_one_overflow;
        ev_two = 8'h00;
        ev_two[`PIF_BIT_OSC] = oscillator_fail;
        ev_two[`PIF_BIT_CMP2] = comparator_two_output ^ cmp2_q;
        ev_two[`PIF_BIT_CMP1] = comparator_one_output ^ cmp1_q;
        ev_two[`PIF_BIT_LCD] = display_driver_event;
        ev_two[`PIF_BIT_LVD] = low_voltage_event;
        ev_two[`PIF_BIT_CC2] = HAS_CC2 & cc_event(capcomp_two_mode,
            capcomp_two_capture, capcomp_two_match);
    end

    // previous comparator levels for change detection
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cmp1_q <= 1'b0;
            cmp2_q <= 1'b0;
        end
        else
        begin
            cmp1_q <= comparator_one_output;
            cmp2_q <= comparator_two_output;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PIF_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `PIF_OFS_FLAGS_ONE, `PIF_OFS_FLAGS_TWO,
                    `PIF_OFS_ENABLE_ONE, `PIF_OFS_ENABLE_TWO,
                    `PIF_OFS_CONTROL, `PIF_OFS_IRQ_STATUS,
                    `PIF_OFS_IRQ_MASK: s_axi_bresp <= `PIF_RESP_OKAY;
                    default: s_axi_bresp <= `PIF_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic wr_hit(input logic [11:0] ofs);
        begin
            wr_hit = wr_fire && (aw_addr == ofs) && w_strb[0];
        end
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////
    // flags; software value first, hardware set overrides
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            flags_one <= `PIF_FLAGS_RESET;
        end
        else
        begin
            if (wr_hit(`PIF_OFS_FLAGS_ONE))
            begin
                flags_one <= (w_data[7:0] | ev_one) & 8'hcf;
            end
            else
            begin
                flags_one <= (flags_one | ev_one) & 8'hcf;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            flags_two <= `PIF_FLAGS_RESET;
        end
        else if (wr_hit(`PIF_OFS_FLAGS_TWO))
        begin
            flags_two <= (w_data[7:0] | ev_two) & two_mask;
        end
        else
        begin
            flags_two <= (flags_two | ev_two) & two_mask;
        end
    end

    // status bits straight from the serial unit, no stored copy
    pif_byte_t view_one;
    always_comb
    begin
        view_one = flags_one;
        view_one[`PIF_BIT_RX] = serial_rx_full;
        view_one[`PIF_BIT_TX] = serial_tx_empty;
    end

    ////////////////////////////////////////////////////////////////////////
    // enables and control
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            enable_one <= 8'h00;
            enable_two <= 8'h00;
            global_irq_enable <= 1'b0;
            peripheral_irq_master_enable <= 1'b0;
            irq_mask <= 2'b00;
        end
        else
        begin
            if (wr_hit(`PIF_OFS_ENABLE_ONE))
            begin
                enable_one <= w_data[7:0];
            end
            if (wr_hit(`PIF_OFS_ENABLE_TWO))
            begin
                enable_two <= w_data[7:0] & two_mask;
            end
            if (wr_hit(`PIF_OFS_CONTROL))
            begin
                global_irq_enable <= w_data[`PIF_CTL_GIE];
                peripheral_irq_master_enable <= w_data[`PIF_CTL_PERIPHERAL_IRQ_MASTER_ENABLE];
            end
            if (wr_hit(`PIF_OFS_IRQ_MASK))
            begin
                irq_mask <= w_data[1:0];
            end
        end
    end

    // request needs flag, enable and master enable
    logic pending;
    assign pending = |(view_one & enable_one) | |(flags_two & enable_two);
    assign peripheral_irq_request = pending && peripheral_irq_master_enable;
    assign core_irq_request = peripheral_irq_request && global_irq_enable;

    // sticky status: bit0 request rise, bit1 write above the irq mask offset; write one clears
    logic req_q;
    logic bad_ev;
    assign bad_ev = wr_fire && (aw_addr > `PIF_OFS_IRQ_MASK);
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            req_q <= 1'b0;
            irq_status <= 2'b00;
        end
        else
        begin
            req_q <= peripheral_irq_request;
            if (wr_hit(`PIF_OFS_IRQ_STATUS))
            begin
                irq_status <= irq_status & ~w_data[1:0];
            end
            // set after clear so a same-cycle event survives
            if (peripheral_irq_request && !req_q)
            begin
                irq_status[0] <= 1'b1;
            end
            if (bad_ev)
            begin
                irq_status[1] <= 1'b1;
            end
        end
    end
    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read channel, one outstanding read
    assign s_axi_arready = (rd_state == PIF_RD_IDLE);
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rd_state <= PIF_RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PIF_RESP_OKAY;
        end
        else
        begin
            case (rd_state)
                PIF_RD_IDLE:
                begin
                    if (s_axi_arvalid)
                    begin
                        rd_state <= PIF_RD_RESP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp <= `PIF_RESP_OKAY;
                        case (s_axi_araddr)
                            `PIF_OFS_FLAGS_ONE:
                                s_axi_rdata <= {24'h0, view_one};
                            `PIF_OFS_FLAGS_TWO:
                                s_axi_rdata <= {24'h0, flags_two};
                            `PIF_OFS_ENABLE_ONE:
                                s_axi_rdata <= {24'h0, enable_one};
                            `PIF_OFS_ENABLE_TWO:
                                s_axi_rdata <= {24'h0, enable_two};
                            `PIF_OFS_CONTROL:
                                s_axi_rdata <= {30'h0,
                                    peripheral_irq_master_enable,
                                    global_irq_enable};
                            `PIF_OFS_IRQ_STATUS:
                                s_axi_rdata <= {30'h0, irq_status};
                            `PIF_OFS_IRQ_MASK:
                                s_axi_rdata <= {30'h0, irq_mask};
                            default:
                            begin
                                s_axi_rdata <= 32'h0000_0000;
                                s_axi_rresp <= `PIF_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                PIF_RD_RESP:
                begin
                    if (s_axi_rready)
                    begin
                        rd_state <= PIF_RD_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default:
                begin
                    rd_state <= PIF_RD_IDLE;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end
endmodule : pif_flags

//--- verification/pif_event_src.sv
// peripheral event source model driving the flag block's event inputs
// assumes tasks are called just after a rising edge of ref_clk
`timescale 1ns/1ps
module pif_event_src
(
    input wire logic ref_clk,
    output logic eeprom_write_done,
    output logic conversion_done,
    output logic serial_rx_full,
    output logic serial_tx_empty,
    output logic sync_serial_done,
    output logic capcomp_one_capture,
    output logic capcomp_one_match,
    output pif_pkg::pif_ccmode_e capcomp_one_mode,
    output logic timer_two_match,
    output logic timer_one_overflow,
    output logic oscillator_fail,
    output logic comparator_one_output,
    output logic comparator_two_output,
    output logic display_driver_event,
    output logic low_voltage_event,
    output logic capcomp_two_capture,
    output logic capcomp_two_match,
    output pif_pkg::pif_ccmode_e capcomp_two_mode
);
    import pif_pkg::*;
    // bit n of pend: flags one bit n, bit 8+n: flags two bit n
    logic [15:0] pend = '0;
    initial
    begin
        serial_rx_full = 1'b0;
        serial_tx_empty = 1'b1;
        capcomp_one_mode = PIF_CC_CAPTURE;
        capcomp_two_mode = PIF_CC_CAPTURE;
        comparator_one_output = 1'b0;
        comparator_two_output = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // pulse only the line the mode listens to, so a swapped decode shows;
    // pwm pulses both, and neither may count
    assign eeprom_write_done = pend[7];
    assign conversion_done = pend[6];
    assign sync_serial_done = pend[3];
    assign capcomp_one_capture = pend[2] &&
        capcomp_one_mode != PIF_CC_COMPARE;
    assign capcomp_one_match = pend[2] &&
        capcomp_one_mode != PIF_CC_CAPTURE;
    assign timer_two_match = pend[1];
    assign timer_one_overflow = pend[0];
    assign oscillator_fail = pend[15];
    assign display_driver_event = pend[12];
    assign low_voltage_event = pend[10];
    assign capcomp_two_capture = pend[8] &&
        capcomp_two_mode != PIF_CC_COMPARE;
    assign capcomp_two_match = pend[8] &&
        capcomp_two_mode != PIF_CC_CAPTURE;
    // comparators are levels: an event is a change of output
    // plain always: the initial block also gives these their start level
    always @(posedge ref_clk)
    begin
        comparator_one_output <= comparator_one_output ^ pend[13];
        comparator_two_output <= comparator_two_output ^ pend[14];
    end
    ////////////////////////////////////////////////////////////////////////
    task fire(input logic [15:0] m);
        pend <= m;
        @(posedge ref_clk);
        pend <= '0;
    endtask : fire
    task set_lv(input logic rx, input logic tx, input pif_ccmode_e a,
                input pif_ccmode_e b);
        serial_rx_full <= rx;
        serial_tx_empty <= tx;
        capcomp_one_mode <= a;
        capcomp_two_mode <= b;
    endtask : set_lv
endmodule : pif_event_src

//--- verification/pif_flags_properties.sv
// port-level checks of the peripheral flag block
// assumes it is bound onto pif_flags, sharing its port names
`timescale 1ns/1ps
`include "pif_consts.svh"
module pif_flags_properties
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic peripheral_irq_request,
    input wire logic core_irq_request,
    input wire logic irq
);
    logic [11:0] rd_addr;
    always_ff @(posedge ref_clk)
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            rd_addr <= s_axi_araddr;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_out(logic [11:0] a);
        $rose(s_axi_rvalid) && rd_addr == a;
    endsequence
    write_answer_a: assert property (both_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
        !s_axi_bvalid && !s_axi_rvalid && !irq && !peripheral_irq_request)
        else $error("reset left outputs active");
    gate_order_a: assert property (core_irq_request |->
        peripheral_irq_request) else $error("core request ungated");
    rx_live_a: assert property (read_out(`PIF_OFS_FLAGS_ONE) |->
        s_axi_rdata[5] == $past(serial_rx_full) &&
        s_axi_rdata[4] == $past(serial_tx_empty))
        else $error("buffer flags not live");
    unused_zero_a: assert property (read_out(`PIF_OFS_FLAGS_TWO) |->
        s_axi_rdata[3] == 1'b0 && s_axi_rdata[1] == 1'b0)
        else $error("unimplemented bits set");
    unmapped_read_a: assert property (read_out(12'h01c) |->
        s_axi_rresp == `PIF_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
endmodule : pif_flags_properties
bind pif_flags pif_flags_properties i_props (.*);

//--- verification/pif_flags_tb.sv
// self-checking bench for the peripheral flag block
// assumes the event source model and the bound property checker
`timescale 1ns/1ps
`include "pif_consts.svh"
module pif_flags_tb;
    import pif_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic eeprom_write_done, conversion_done, serial_rx_full;
    logic serial_tx_empty, sync_serial_done, capcomp_one_capture;
    logic capcomp_one_match, timer_two_match, timer_one_overflow;
    logic oscillator_fail, comparator_one_output, comparator_two_output;
    logic display_driver_event, low_voltage_event, capcomp_two_capture;
    logic capcomp_two_match, peripheral_irq_request, core_irq_request, irq;
    pif_ccmode_e capcomp_one_mode, capcomp_two_mode, md1, md2;
    int num_errors = 0, compares = 0;
    integer seed = 32'h9bf51db2;
    logic [7:0] m1, m2;
    logic [31:0] e, d;
    always #12.5 ref_clk = ~ref_clk;
    pif_flags i_dut (.*);
    pif_event_src ev (.*);
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_val
    task chk_sig(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask : chk_sig
    task wr(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !s_axi_bvalid; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (n == 50) begin num_errors++; complete_run(); end
        chk_val({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task rchk(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !s_axi_rvalid; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (n == 50) begin num_errors++; complete_run(); end
        chk_val(s_axi_rdata, ex);
        chk_val({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rchk
    // flags one bits 5 and 4 follow the serial buffer levels
    function automatic logic [31:0] exp_one(input logic [7:0] m);
        return {24'h0, m[7:6], serial_rx_full, serial_tx_empty, m[3:0]};
    endfunction : exp_one
    // capture/compare flag (bit 2 or bit 0) has no event in pwm mode
    function automatic logic [7:0] evset(input logic [7:0] v,
        input pif_ccmode_e md, input logic [7:0] msk, input int cc);
        logic [7:0] r;
        r = v & msk;
        if (md == PIF_CC_PWM) r[cc] = 1'b0;
        return r;
    endfunction : evset
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        m1 = '0;
        m2 = '0;
        for (int a = 0; a < 7; a++)
            rchk(12'(a * 4), a == 0 ? exp_one(0) : 0, `PIF_RESP_OKAY);
        rchk(12'h01c, 32'h0, `PIF_RESP_SLVERR);
        wr(12'h01c, 32'hff, `PIF_RESP_SLVERR);
        rchk(`PIF_OFS_IRQ_STATUS, 32'h2, `PIF_RESP_OKAY);
        chk_sig(irq, 1'b0);
        wr(`PIF_OFS_IRQ_MASK, 32'h3, `PIF_RESP_OKAY);
        chk_sig(irq, 1'b1);
        wr(`PIF_OFS_IRQ_STATUS, 32'h2, `PIF_RESP_OKAY);
        chk_sig(irq, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            e = $random(seed);
            if (i == 0) e[15:0] = 16'hffff;
            md1 = pif_ccmode_e'(e[19:18] % 2'd3);
            md2 = pif_ccmode_e'(e[21:20] % 2'd3);
            ev.set_lv(e[16], e[17], md1, md2);
            ev.fire(e[15:0]);
            m1 = m1 | evset(e[7:0], md1, 8'hcf, 2);
            m2 = m2 | evset(e[15:8], md2, 8'hf5, 0);
            repeat (2) @(posedge ref_clk);
            rchk(`PIF_OFS_FLAGS_ONE, exp_one(m1), 0);
            rchk(`PIF_OFS_FLAGS_TWO, {24'h0, m2}, 0);
            d = $random(seed);
            wr(`PIF_OFS_FLAGS_ONE, d, `PIF_RESP_OKAY);
            wr(`PIF_OFS_FLAGS_TWO, d >> 8, `PIF_RESP_OKAY);
            m1 = d[7:0] & 8'hcf;
            m2 = d[15:8] & 8'hf5;
        end
        wr(`PIF_OFS_FLAGS_ONE, 32'h0, `PIF_RESP_OKAY);
        wr(`PIF_OFS_ENABLE_ONE, 32'h1, `PIF_RESP_OKAY);
        ev.fire(16'h0001);
        for (int c = 0; c < 4; c++)
        begin
            wr(`PIF_OFS_CONTROL, c, `PIF_RESP_OKAY);
            chk_sig(peripheral_irq_request, c[1]);
            chk_sig(core_irq_request, c == 3);
        end
        wr(`PIF_OFS_IRQ_MASK, 32'h1, `PIF_RESP_OKAY);
        chk_sig(irq, 1'b1);
        wr(`PIF_OFS_IRQ_STATUS, 32'h1, `PIF_RESP_OKAY);
        chk_sig(irq, 1'b0);
        // clear lands on the edge the event pulse is sampled
        fork
            wr(`PIF_OFS_FLAGS_ONE, 32'h0, `PIF_RESP_OKAY);
            begin
                @(posedge ref_clk);
                ev.fire(16'h0080);
            end
        join
        rchk(`PIF_OFS_FLAGS_ONE, exp_one(8'h80), 0);
        // mid-run reset; comparator history restarts at zero
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rchk(`PIF_OFS_FLAGS_ONE, exp_one(8'h00), 0);
        rchk(`PIF_OFS_FLAGS_TWO, {25'h0, comparator_two_output,
            comparator_one_output, 5'h00}, 0);
        rchk(`PIF_OFS_CONTROL, 32'h0, 0);
        complete_run();
    end
endmodule : pif_flags_tb
